// >>> hdl/nps_sequencer.v
// Purpose: Serial NOR program and erase command sequencer
// Assumes: Serial clock well below mclk/4; pins sampled by mclk
// Notes:   Array is outside; writes and erases leave as strobes
`timescale 1ns/1ns
`default_nettype none
`include "nps_regs.vh"

// Notes on behaviour
// - 12h, 34h, 3Eh take 32-bit address
// - Address width from strap or enter/exit
// - Dedicated 4-byte commands always four bytes
// - Bits per clock follow lane count
// - Erase drives bits to one
// - Erase without write enable ignored silently
// - Off-boundary select rise: nothing, latch kept
// - Erase self-timed per command kind
// - Protected sector: no erase, flags 1,5
// - Erase busy: controller 0, WIP 1
// - End clears WIP and write enable
// - Timeout clears latch, sets erase error (program error for a program)
// - Any address picks whole region
// - Sector erases suspend and resume
// - Bulk refused if any sector locked
// - Address bits taken on clock rise
// - Flags pollable; ready returns to 1
// - Program only clears bits
// - Protected program: no change, flags 1,4
module nps_sequencer #(
  parameter PAGE_BITS = `NPS_PAGE_BITS,
  parameter SECTORS   = `NPS_SECTORS,
  parameter SSE_CYC   = `NPS_SUBSECTOR_ERASE_TIME_US * `NPS_MCLK_MHZ,
  parameter SE_CYC    = `NPS_SECTOR_ERASE_TIME_US * `NPS_MCLK_MHZ,
  parameter BE_CYC    = `NPS_BULK_ERASE_TIME_US * `NPS_MCLK_MHZ,
  parameter PP_CYC    = `NPS_PAGE_PROGRAM_TIME_US * `NPS_MCLK_MHZ,
  parameter TOUT_CYC  = `NPS_TIMEOUT_TIME_US * `NPS_MCLK_MHZ
) (
  // Clock and reset
  input  wire               mclk,
  input  wire               reset,
  // Serial pins
  input  wire               sclkPin,
  input  wire               csNPin,
  input  wire [3:0]         dqPin,
  // Configuration
  input  wire               nvAddr4,
  input  wire [1:0]         laneMode,
  input  wire [SECTORS-1:0] sectorLock,
  input  wire               arrayStuck,
  // Array strobes
  output reg                memWrite,
  output reg  [7:0]         memClearMask,
  output reg                memErase,
  output reg  [1:0]         memEraseKind,
  output reg  [31:0]        memAddr,
  // Status
  output reg                wip,
  output reg                wel,
  output wire [7:0]         flagStatus
);

  localparam PAGE = 1 << PAGE_BITS;
  localparam SIDX = `NPS_SECTOR_BITS;
  // Kinds of decoded command
  localparam K_NONE = 4'd0;
  localparam K_WREN = 4'd1;
  localparam K_WRDI = 4'd2;
  localparam K_EN4  = 4'd3;
  localparam K_EX4  = 4'd4;
  localparam K_CLRF = 4'd5;
  localparam K_SUSP = 4'd6;
  localparam K_RES  = 4'd7;
  localparam K_PROG = 4'd8;
  localparam K_SSE  = 4'd9;
  localparam K_SE   = 4'd10;
  localparam K_BE   = 4'd11;
  // Sequencer states
  localparam S_IDLE = 2'd0;
  localparam S_BUSY = 2'd1;
  localparam S_SUSP = 2'd2;

  // Synchronised pins
  wire [5:0] pinSync;
  wire       csS   = pinSync[5];
  wire       sclkS = pinSync[4];
  wire [3:0] dqS   = pinSync[3:0];

  nps_sync #(
    .WIDTH (6),
    .INIT  (`NPS_PIN_RESET)
  ) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   ({csNPin, sclkPin, dqPin}),
    .dout  (pinSync)
  );

  reg        sclkPrev;
  reg        csPrev;
  reg [7:0]  shift;
  reg [3:0]  bitCnt;
  reg [9:0]  byteIdx;
  reg [3:0]  kind;
  reg [2:0]  addrBytes;
  reg [31:0] addr;
  reg [8:0]  dataCnt;
  reg [7:0]  page [0:PAGE-1];
  reg [PAGE-1:0] pageValid;
  reg [1:0]  state;
  reg [3:0]  opKind;
  reg [31:0] opAddr;
  reg [31:0] opCnt;
  reg [31:0] opDur;
  reg        addr4Mode;
  reg        strapDone;
  reg        eraseErr;
  reg        progErr;
  reg        protErr;
  reg        eraseSusp;
  reg        ready;
  reg [7:0]  nextShift;
  reg [3:0]  nextBits;
  reg [3:0]  decKind;
  reg [2:0]  decBytes;

  wire sclkRise = sclkS & ~sclkPrev;
  wire csRise   = csS & ~csPrev;
  wire csFall   = ~csS & csPrev;
  wire byteDone = sclkRise & ~csS & (nextBits == 4'd8);
  wire [PAGE_BITS-1:0] pageIdx = addr[PAGE_BITS-1:0] +
                                 dataCnt[PAGE_BITS-1:0];
  wire [9:0] hdrLen = {7'h00, addrBytes} + 10'h001;
  wire [PAGE_BITS-1:0] wrIdx = opCnt[PAGE_BITS-1:0];
  wire hitLock  = sectorLock[addr[SIDX +: 10]];
  wire anyLock  = |sectorLock;
  wire onByte   = (bitCnt == 4'd0);
  wire isErase  = (kind == K_SSE) | (kind == K_SE) | (kind == K_BE);

  assign flagStatus = {ready, eraseSusp, eraseErr, progErr,
                       2'b00, protErr, addr4Mode};

  // Lane width sets bits per clock in every phase
  always @* begin
    case (laneMode)
      2'd1: begin
        nextShift = {shift[5:0], dqS[1:0]};
        nextBits  = bitCnt + 4'd2;
      end
      2'd2: begin
        nextShift = {shift[3:0], dqS};
        nextBits  = bitCnt + 4'd4;
      end
      default: begin
        nextShift = {shift[6:0], dqS[0]};
        nextBits  = bitCnt + 4'd1;
      end
    endcase
  end

  // Opcode decode; the assembled byte is still in nextShift
  always @* begin
    decBytes = addr4Mode ? 3'd4 : 3'd3;
    case (nextShift)
      `NPS_OP_WREN:  decKind = K_WREN;
      `NPS_OP_WRDI:  decKind = K_WRDI;
      `NPS_OP_EN4:   decKind = K_EN4;
      `NPS_OP_EX4:   decKind = K_EX4;
      `NPS_OP_CLRF:  decKind = K_CLRF;
      `NPS_OP_SUSP:  decKind = K_SUSP;
      `NPS_OP_RES:   decKind = K_RES;
      `NPS_OP_PP, `NPS_OP_DIFP, `NPS_OP_EDIFP,
      `NPS_OP_QIFP, `NPS_OP_EQIFP: decKind = K_PROG;
      `NPS_OP_PP4, `NPS_OP_QIFP4, `NPS_OP_EQIFP4: begin
        decKind  = K_PROG;
        decBytes = 3'd4;
      end
      `NPS_OP_SSE_A, `NPS_OP_SSE_B: decKind = K_SSE;
      `NPS_OP_SE:    decKind = K_SE;
      `NPS_OP_BE_A, `NPS_OP_BE_B: decKind = K_BE;
      default:       decKind = K_NONE;
    endcase
  end

  // Frame capture: bytes assembled on serial clock rises
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      sclkPrev  <= 1'b0;
      csPrev    <= 1'b1;
      shift     <= 8'h00;
      bitCnt    <= 4'h0;
      byteIdx   <= 10'h000;
      kind      <= K_NONE;
      addrBytes <= 3'd3;
      addr      <= 32'h0000_0000;
      dataCnt   <= 9'h000;
      pageValid <= {PAGE{1'b0}};
    end else begin
      sclkPrev <= sclkS;
      csPrev   <= csS;
      if (csFall) begin
        bitCnt    <= 4'h0;
        byteIdx   <= 10'h000;
        kind      <= K_NONE;
        dataCnt   <= 9'h000;
        pageValid <= {PAGE{1'b0}};
      end else if (sclkRise && !csS) begin
        shift  <= nextShift;
        bitCnt <= byteDone ? 4'h0 : nextBits;
        if (byteDone) begin
          if (byteIdx != 10'h3FF)
            byteIdx <= byteIdx + 10'h001;
          if (byteIdx == 10'h000) begin
            kind      <= decKind;
            addrBytes <= decBytes;
            // A 3-byte address must not inherit an older high byte
            addr      <= 32'h0000_0000;
          end else if (byteIdx < hdrLen) begin
            addr <= {addr[23:0], nextShift};
          end else if (kind == K_PROG) begin
            pageValid[pageIdx] <= 1'b1;
            if (dataCnt != 9'h1FF)
              dataCnt <= dataCnt + 9'h001;
          end
        end
      end
    end
  end

  // Page buffer has no reset; validity bits guard its use
  always @(posedge mclk) begin
    if (byteDone && kind == K_PROG && byteIdx >= hdrLen &&
        !csS && byteIdx != 10'h000)
      page[pageIdx] <= nextShift;
  end

  // Command execution and self-timed operation
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state        <= S_IDLE;
      opKind       <= K_NONE;
      opAddr       <= 32'h0000_0000;
      opCnt        <= 32'h0000_0000;
      opDur        <= 32'h0000_0001;
      wip          <= 1'b0;
      wel          <= 1'b0;
      ready        <= 1'b1;
      eraseErr     <= 1'b0;
      progErr      <= 1'b0;
      protErr      <= 1'b0;
      eraseSusp    <= 1'b0;
      addr4Mode    <= 1'b0;
      strapDone    <= 1'b0;
      memWrite     <= 1'b0;
      memClearMask <= 8'h00;
      memErase     <= 1'b0;
      memEraseKind <= `NPS_EK_SUB;
      memAddr      <= 32'h0000_0000;
    end else begin
      memWrite <= 1'b0;
      memErase <= 1'b0;
      // Nonvolatile width setting is caught once after reset
      if (!strapDone) begin
        addr4Mode <= nvAddr4;
        strapDone <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          // Only a whole-byte frame of proper length executes
          if (csRise && onByte) begin
            case (kind)
              K_WREN: if (byteIdx == 10'h001) wel <= 1'b1;
              K_WRDI: if (byteIdx == 10'h001) wel <= 1'b0;
              K_EN4:  if (byteIdx == 10'h001) addr4Mode <= 1'b1;
              K_EX4:  if (byteIdx == 10'h001) addr4Mode <= 1'b0;
              K_CLRF: if (byteIdx == 10'h001) begin
                eraseErr <= 1'b0;
                progErr  <= 1'b0;
                protErr  <= 1'b0;
              end
              K_PROG: if (wel && byteIdx > hdrLen) begin
                if (hitLock) begin
                  protErr <= 1'b1;
                  progErr <= 1'b1;
                end else begin
                  state  <= S_BUSY;
                  opKind <= K_PROG;
                  opAddr <= addr;
                  opDur  <= PP_CYC;
                  opCnt  <= 32'h0000_0000;
                  wip    <= 1'b1;
                  ready  <= 1'b0;
                end
              end
              K_SSE, K_SE, K_BE: begin
                // Without the latch the erase is dropped silently
                if (wel && byteIdx == ((kind == K_BE) ? 10'h001
                                                      : hdrLen)) begin
                  if ((kind == K_BE) ? anyLock : hitLock) begin
                    protErr <= 1'b1;
                    eraseErr <= 1'b1;
                  end else begin
                    state  <= S_BUSY;
                    opKind <= kind;
                    opAddr <= addr;
                    opDur  <= (kind == K_SSE) ? SSE_CYC :
                              (kind == K_SE)  ? SE_CYC : BE_CYC;
                    opCnt  <= 32'h0000_0000;
                    wip    <= 1'b1;
                    ready  <= 1'b0;
                  end
                end
              end
              default: ;
            endcase
          end
        end
        S_BUSY: begin
          opCnt <= opCnt + 32'h0000_0001;
          // Program pass: one clear-mask strobe per buffered byte
          if (opKind == K_PROG && opCnt < PAGE &&
              pageValid[wrIdx]) begin
            memWrite     <= 1'b1;
            memAddr      <= {opAddr[31:PAGE_BITS], wrIdx};
            memClearMask <= ~page[wrIdx];
          end
          if (opCnt >= opDur - 32'h0000_0001 && !arrayStuck) begin
            state <= S_IDLE;
            wip   <= 1'b0;
            wel   <= 1'b0;
            ready <= 1'b1;
            if (opKind != K_PROG) begin
              memErase <= 1'b1;
              case (opKind)
                K_SSE: begin
                  memEraseKind <= `NPS_EK_SUB;
                  memAddr <= {opAddr[31:`NPS_SUBSEC_BITS],
                              {`NPS_SUBSEC_BITS{1'b0}}};
                end
                K_SE: begin
                  memEraseKind <= `NPS_EK_SEC;
                  memAddr <= {opAddr[31:`NPS_SECTOR_BITS],
                              {`NPS_SECTOR_BITS{1'b0}}};
                end
                default: begin
                  memEraseKind <= `NPS_EK_BULK;
                  memAddr      <= 32'h0000_0000;
                end
              endcase
            end
          end else if (opCnt >= TOUT_CYC - 1) begin
            // The array never finished: give up and report
            state <= S_IDLE;
            wip   <= 1'b0;
            wel   <= 1'b0;
            ready <= 1'b1;
            if (opKind == K_PROG)
              progErr <= 1'b1;
            else
              eraseErr <= 1'b1;
          end else if (csRise && onByte && kind == K_SUSP &&
                       byteIdx == 10'h001 &&
                       (opKind == K_SSE || opKind == K_SE)) begin
            state     <= S_SUSP;
            eraseSusp <= 1'b1;
            wip       <= 1'b0;
            ready     <= 1'b1;
          end
        end
        S_SUSP: begin
          // Elapsed time is kept; the erase continues where it stopped
          if (csRise && onByte && byteIdx == 10'h001) begin
            case (kind)
              K_RES: begin
                state     <= S_BUSY;
                eraseSusp <= 1'b0;
                wip       <= 1'b1;
                ready     <= 1'b0;
              end
              K_WREN: wel <= 1'b1;
              K_WRDI: wel <= 1'b0;
              K_CLRF: begin
                eraseErr <= 1'b0;
                progErr  <= 1'b0;
                protErr  <= 1'b0;
              end
              default: ;
            endcase
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // nps_sequencer
`default_nettype wire

// >>> hdl/nps_regs.vh
// Purpose: Constants of the program/erase command sequencer
// Assumes: Included by nps_sync.v and nps_sequencer.v
// Notes:   Times are in microseconds; cycle counts derive from MCLK_MHZ
`ifndef NPS_REGS_VH
`define NPS_REGS_VH

// Command codes
`define NPS_OP_WREN      8'h06
`define NPS_OP_WRDI      8'h04
`define NPS_OP_EN4       8'hB7
`define NPS_OP_EX4       8'hE9
`define NPS_OP_CLRF      8'h50
`define NPS_OP_SUSP      8'h75
`define NPS_OP_RES       8'h7A
`define NPS_OP_PP        8'h02
`define NPS_OP_DIFP      8'hA2
`define NPS_OP_EDIFP     8'hD2
`define NPS_OP_QIFP      8'h32
`define NPS_OP_EQIFP     8'h38
`define NPS_OP_PP4       8'h12
`define NPS_OP_QIFP4     8'h34
`define NPS_OP_EQIFP4    8'h3E
`define NPS_OP_SSE_A     8'h52
`define NPS_OP_SSE_B     8'h20
`define NPS_OP_SE        8'hD8
`define NPS_OP_BE_A      8'hC7
`define NPS_OP_BE_B      8'h60

// Flag status bit positions
`define NPS_FL_READY     7
`define NPS_FL_ESUSP     6
`define NPS_FL_EERR      5
`define NPS_FL_PERR      4
`define NPS_FL_PROT      1
`define NPS_FL_ADDR4     0

// Erase region kinds shown on memEraseKind
`define NPS_EK_SUB       2'h0
`define NPS_EK_SEC       2'h1
`define NPS_EK_BULK      2'h2

// Geometry: region sizes as address bit counts, plus the number of sectors
`define NPS_PAGE_BITS    8
`define NPS_SUBSEC_BITS  12
`define NPS_SECTOR_BITS  16
`define NPS_SECTORS      1024

// Reset value of the pin synchroniser: chip select idles high
`define NPS_PIN_RESET    6'h20

// Timing
`define NPS_MCLK_MHZ                 100
`define NPS_SUBSECTOR_ERASE_TIME_US  120
`define NPS_SECTOR_ERASE_TIME_US     400
`define NPS_BULK_ERASE_TIME_US       2000
`define NPS_PAGE_PROGRAM_TIME_US     60
`define NPS_TIMEOUT_TIME_US          5000

`endif

// >>> hdl/nps_sync.v
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to mclk
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ns
`default_nettype none
`include "nps_regs.vh"

module nps_sync #(
  parameter          WIDTH = 6,
  parameter [5:0]    INIT  = `NPS_PIN_RESET
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             reset,
  // Data
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage1 <= INIT[WIDTH-1:0];
      dout   <= INIT[WIDTH-1:0];
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // nps_sync
`default_nettype wire

// >>> test/nps_seq_props.sv
// Purpose: Port assertions for the program/erase sequencer
// Assumes: One mclk domain, asynchronous active-high reset
// Notes:   TOUT_CYC is handed on from the bound instance
`timescale 1ns/1ns
`default_nettype none
module nps_seq_props #(
  parameter TOUT_CYC = 2000
) (
  // Clock and reset
  input wire        mclk,
  input wire        reset,
  // Array strobes
  input wire        memWrite,
  input wire        memErase,
  input wire [1:0]  memEraseKind,
  input wire [31:0] memAddr,
  // Status
  input wire        wip,
  input wire        wel,
  input wire [7:0]  flagStatus
);
  reg [31:0] busyCnt;
  // Busy stretch length; a stuck array must still end by timeout
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      busyCnt <= 32'h0000_0000;
    end else begin
      busyCnt <= wip ? busyCnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_ready_not_busy: assert property (flagStatus[7] == !wip)
    else $error("ready bit disagrees with busy");
  a_erase_one_pulse: assert property (memErase |=> !memErase)
    else $error("erase strobe longer than one cycle");
  a_erase_ends_op: assert property (memErase |-> !wip && !wel)
    else $error("erase strobe without completion");
  a_erase_after_busy: assert property (memErase |-> $past(wip))
    else $error("erase strobe without a busy phase");
  a_region_base: assert property (memErase |->
    (memEraseKind == 2'h0 && memAddr[11:0] == 12'h000) ||
    (memEraseKind == 2'h1 && memAddr[15:0] == 16'h0000) ||
    (memEraseKind == 2'h2 && memAddr == 32'h0000_0000))
    else $error("erase region base not aligned");
  a_write_in_busy: assert property (memWrite |-> wip)
    else $error("byte write outside an operation");
  a_start_needs_wel: assert property ($rose(wip) |-> wel)
    else $error("operation started without write enable");
  a_prot_keeps_wel: assert property ($rose(flagStatus[1]) |-> wel && !wip)
    else $error("protection error with wrong latch or busy");
  a_err_clears_wel: assert property ($rose(flagStatus[5]) |->
    !wel || flagStatus[1])
    else $error("erase error without latch clear");
  a_done_drops_wel: assert property ($fell(wip) && !flagStatus[6] |-> !wel)
    else $error("latch still set after completion");
  a_busy_bounded: assert property (busyCnt <= TOUT_CYC + 2)
    else $error("operation outlived the timeout");
endmodule // nps_seq_props
bind nps_sequencer nps_seq_props #(.TOUT_CYC(TOUT_CYC)) props (
  .mclk(mclk), .reset(reset), .memWrite(memWrite), .memErase(memErase),
  .memEraseKind(memEraseKind), .memAddr(memAddr), .wip(wip), .wel(wel),
  .flagStatus(flagStatus)
);
`default_nettype wire

// >>> test/nps_host_model.sv
// Purpose: Serial host that frames commands toward the sequencer
// Assumes: Link clock of 80 ns, made from mclk falling edges
// Notes:   Clock idles low and stands still between frames
`timescale 1ns/1ns
`default_nettype none
module nps_host_model (
  // Clock
  input  wire        mclk,
  // Serial pins
  output logic       sclkPin,
  output logic       csNPin,
  output logic [3:0] dqPin
);
  // Idle bus before the first frame
  initial begin
    sclkPin = 1'h0;
    csNPin = 1'h1;
    dqPin = 4'h0;
  end
  // One frame, MSB first; nb may stop short of a byte on purpose
  task automatic send(input logic [63:0] v, input int nb, input int ln);
    @(negedge mclk);
    csNPin = 1'h0;
    for (int i = 0; i < nb; i += ln) begin
      for (int k = 0; k < ln; k++) dqPin[ln-1-k] = v[63-i-k];
      repeat (4) @(negedge mclk);
      sclkPin = 1'h1;
      repeat (4) @(negedge mclk);
      sclkPin = 1'h0;
    end
    repeat (4) @(negedge mclk);
    csNPin = 1'h1;
    dqPin = ~dqPin; // Released lines must not keep the last value
    repeat (8) @(negedge mclk);
  endtask
endmodule // nps_host_model
`default_nettype wire

// >>> test/testbench.sv
// Purpose: Self-checking bench for the program/erase sequencer
// Assumes: Host model owns the serial pins; mclk at 100 MHz
// Notes:   Operation times shortened by parameter for run length
`timescale 1ns/1ns
`default_nettype none
`include "nps_regs.vh"
module testbench;
  localparam int SSE = 400;
  localparam int SE = 600;
  localparam int BE = 800;
  localparam int PP = 300;
  localparam int TO = 2000;
  // Clock, reset and configuration
  logic          mclk;
  logic          reset;
  logic          nvAddr4;
  logic [1:0]    laneMode;
  logic [1023:0] sectorLock;
  logic          arrayStuck;
  // Pins and results
  wire           sclkPin;
  wire           csNPin;
  wire  [3:0]    dqPin;
  wire           memWrite;
  wire  [7:0]    memClearMask;
  wire           memErase;
  wire  [1:0]    memEraseKind;
  wire  [31:0]   memAddr;
  wire           wip;
  wire           wel;
  wire  [7:0]    flagStatus;
  // Bench bookkeeping
  int            fails;
  int            n_checks;
  int            busyCyc;
  logic          seenErase;
  logic          seenWrite;
  logic [1:0]    eKind;
  logic [31:0]   eAddr;
  logic [31:0]   wAddr;
  logic [7:0]    wMask;

  nps_sequencer #(.SSE_CYC(SSE), .SE_CYC(SE), .BE_CYC(BE), .PP_CYC(PP),
    .TOUT_CYC(TO)) uut (
    .mclk(mclk), .reset(reset), .sclkPin(sclkPin), .csNPin(csNPin),
    .dqPin(dqPin), .nvAddr4(nvAddr4), .laneMode(laneMode),
    .sectorLock(sectorLock), .arrayStuck(arrayStuck), .memWrite(memWrite),
    .memClearMask(memClearMask), .memErase(memErase),
    .memEraseKind(memEraseKind), .memAddr(memAddr), .wip(wip), .wel(wel),
    .flagStatus(flagStatus));
  nps_host_model host (.mclk(mclk), .sclkPin(sclkPin), .csNPin(csNPin),
    .dqPin(dqPin));

  // Free-running clock
  always #5 mclk = ~mclk;
  // Strobes last one cycle, so they are watched all the time
  always @(negedge mclk) begin
    if (wip === 1'h1) busyCyc++;
    if (memErase === 1'h1) begin
      seenErase = 1'h1;
      eKind = memEraseKind;
      eAddr = memAddr;
    end
    if (memWrite === 1'h1) begin
      seenWrite = 1'h1;
      wAddr = memAddr;
      wMask = memClearMask;
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int g);
    n_checks++;
    if (g < lo || g > lo + 4) begin
      fails++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, lo + 4, g);
    end
  endtask
  task automatic stat(input logic [7:0] f, input logic l, input logic b);
    chk("flags", {24'h0, f}, {24'h0, flagStatus});
    chk("wel", {31'h0, l}, {31'h0, wel});
    chk("wip", {31'h0, b}, {31'h0, wip});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic clr();
    seenErase = 1'h0;
    seenWrite = 1'h0;
    busyCyc = 0;
  endtask
  task automatic cmd(input logic [7:0] op, input int ln);
    host.send({op, 56'h0}, 8, ln);
  endtask
  // Bounded wait for the end of an operation
  task automatic wait_idle();
    int n;
    n = 0;
    while (wip !== 1'h0) begin
      @(negedge mclk);
      n++;
      if (n > 3000) begin
        fails++;
        $display("Error wip expected 0 seen %b", wip);
        give_verdict();
      end
    end
    idle(1);
  endtask

  task automatic t_gating();
    clr();
    host.send({`NPS_OP_SSE_B, 24'h00_1000, 32'h0}, 32, 1);
    idle(20);
    stat(8'h80, 1'h0, 1'h0);
    cmd(`NPS_OP_WREN, 1);
    host.send({`NPS_OP_SSE_B, 24'h00_1000, 32'h0}, 36, 1);
    idle(20);
    stat(8'h80, 1'h1, 1'h0);
    chk("erase", 0, {31'h0, seenErase});
  endtask
  task automatic t_erase_all();
    logic [7:0] op [5] = '{`NPS_OP_SSE_A, `NPS_OP_SSE_B, `NPS_OP_SE,
                           `NPS_OP_BE_A, `NPS_OP_BE_B};
    logic [1:0] kd [5] = '{`NPS_EK_SUB, `NPS_EK_SUB, `NPS_EK_SEC,
                           `NPS_EK_BULK, `NPS_EK_BULK};
    logic [31:0] ba [5] = '{32'h0001_2000, 32'h0001_2000, 32'h0001_0000,
                            32'h0000_0000, 32'h0000_0000};
    int dur [5] = '{SSE, SSE, SE, BE, BE};
    for (int i = 0; i < 5; i++) begin
      cmd(`NPS_OP_WREN, 1);
      clr();
      host.send({op[i], 24'h01_2345, 32'h0}, (i < 3) ? 32 : 8, 1);
      stat(8'h00, 1'h1, 1'h1);
      wait_idle();
      stat(8'h80, 1'h0, 1'h0);
      chk("erase", 1, {31'h0, seenErase});
      chk("kind", {30'h0, kd[i]}, {30'h0, eKind});
      chk("base", ba[i], eAddr);
      chk_rng("busy", dur[i] - 2, busyCyc);
    end
  endtask
  task automatic t_addr4();
    cmd(`NPS_OP_EN4, 1);
    stat(8'h81, 1'h0, 1'h0);
    cmd(`NPS_OP_WREN, 1);
    clr();
    host.send({`NPS_OP_SE, 32'h0234_5678, 24'h0}, 40, 1);
    wait_idle();
    chk("base", 32'h0234_0000, eAddr);
    cmd(`NPS_OP_EX4, 1);
    stat(8'h80, 1'h0, 1'h0);
  endtask
  // Every program code; the first three always carry four address bytes
  task automatic t_program();
    logic [7:0] op [8] = '{`NPS_OP_PP4, `NPS_OP_QIFP4, `NPS_OP_EQIFP4,
                           `NPS_OP_PP, `NPS_OP_DIFP, `NPS_OP_EDIFP,
                           `NPS_OP_QIFP, `NPS_OP_EQIFP};
    logic [31:0] wa;
    for (int i = 0; i < 8; i++) begin
      laneMode = 2'h1;
      cmd(`NPS_OP_WREN, 2);
      stat(8'h80, 1'h1, 1'h0);
      laneMode = 2'h2;
      clr();
      wa = (i < 3) ? 32'h0300_0010 : 32'h0003_0010;
      if (i < 3) host.send({op[i], wa, 8'h5A, 16'h0}, 48, 4);
      else host.send({op[i], wa[23:0], 8'h5A, 24'h0}, 40, 4);
      wait_idle();
      laneMode = 2'h0;
      chk("write", 1, {31'h0, seenWrite});
      chk("waddr", wa, wAddr);
      chk("mask", 32'h0000_00A5, {24'h0, wMask});
      chk_rng("busy", PP - 2, busyCyc);
      stat(8'h80, 1'h0, 1'h0);
    end
  endtask
  task automatic t_protect();
    sectorLock[1] = 1'h1;
    cmd(`NPS_OP_WREN, 1);
    clr();
    host.send({`NPS_OP_SSE_A, 24'h01_2345, 32'h0}, 32, 1);
    stat(8'hA2, 1'h1, 1'h0);
    cmd(`NPS_OP_CLRF, 1);
    cmd(`NPS_OP_BE_A, 1);
    stat(8'hA2, 1'h1, 1'h0);
    cmd(`NPS_OP_CLRF, 1);
    host.send({`NPS_OP_PP, 24'h01_0000, 8'h00, 24'h0}, 40, 1);
    stat(8'h92, 1'h1, 1'h0);
    chk("strobes", 0, {30'h0, seenErase, seenWrite});
    cmd(`NPS_OP_CLRF, 1);
    sectorLock[1] = 1'h0;
    cmd(`NPS_OP_WRDI, 1);
    stat(8'h80, 1'h0, 1'h0);
  endtask
  task automatic t_timeout();
    arrayStuck = 1'h1;
    cmd(`NPS_OP_WREN, 1);
    clr();
    host.send({`NPS_OP_SSE_B, 24'h00_0000, 32'h0}, 32, 1);
    wait_idle();
    arrayStuck = 1'h0;
    stat(8'hA0, 1'h0, 1'h0);
    chk("erase", 0, {31'h0, seenErase});
    chk_rng("busy", TO - 2, busyCyc);
    cmd(`NPS_OP_CLRF, 1);
  endtask
  task automatic t_suspend();
    cmd(`NPS_OP_WREN, 1);
    clr();
    host.send({`NPS_OP_SSE_A, 24'h00_3000, 32'h0}, 32, 1);
    cmd(`NPS_OP_SUSP, 1);
    stat(8'hC0, 1'h1, 1'h0);
    idle(500);
    chk("erase", 0, {31'h0, seenErase});
    cmd(`NPS_OP_RES, 1);
    stat(8'h00, 1'h1, 1'h1);
    wait_idle();
    chk("erase", 1, {31'h0, seenErase});
  endtask

  initial begin
    mclk = 1'h0;
    reset = 1'h1;
    nvAddr4 = 1'h0;
    laneMode = 2'h0;
    sectorLock = '0;
    arrayStuck = 1'h0;
    fails = 0;
    n_checks = 0;
    clr();
    idle(16);
    reset = 1'h0;
    idle(4);
    stat(8'h80, 1'h0, 1'h0);
    t_gating();
    t_erase_all();
    t_addr4();
    t_program();
    t_protect();
    t_timeout();
    t_suspend();
    nvAddr4 = 1'h1;
    reset = 1'h1;
    idle(2);
    reset = 1'h0;
    idle(4);
    stat(8'h81, 1'h0, 1'h0);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
